//--- inc/fabric_bridge_pkg.sv
// Package for the indirect fabric register access bridge
package fabric_bridge_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] DATA_REG_OFFSET = 12'h1AC;
    localparam logic [11:0] CMD_REG_OFFSET = 12'h1B0;

    // ------------------------------------------------------------
    // Command register fields
    // ------------------------------------------------------------
    localparam int PENDING_BIT = 31;
    localparam int DIR_BIT = 30;
    localparam int STEP_UP_BIT = 29;
    localparam int STEP_DOWN_BIT = 28;
    localparam int LANE_LSB = 16;
    localparam int LANE_MSB = 19;
    localparam int INDEX_LSB = 0;
    localparam int INDEX_MSB = 15;
    localparam logic [31:0] CMD_RESET = 32'h0000_0000;
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic req;
        logic rd_nwr;
        logic [15:0] index;
        logic [3:0] lanes;
        logic [31:0] wdata;
    } fabric_req_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DONE = 3'b100
    } bridge_state_t;

endpackage : fabric_bridge_pkg

//--- hw/fabric_bridge.sv
// Indirect access bridge from host registers to the switch fabric register port
`timescale 1ns/1ns
module fabric_bridge (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Host register port
    input fabric_bridge_pkg::host_req_t host_req_i,
    output logic [31:0] host_rdata_o,
    // Fabric register port
    output fabric_bridge_pkg::fabric_req_t fabric_req_o,
    input wire logic fabric_done_i,
    input wire logic [31:0] fabric_rdata_i
);
    import fabric_bridge_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Address step helper
    // ------------------------------------------------------------
    function automatic logic [15:0] step_index(input logic [15:0] idx, input logic up,
                                               input logic down);
        if (up)
        begin
            return idx + 16'h0001;
        end
        else if (down)
        begin
            return idx - 16'h0001;
        end
        return idx;
    endfunction : step_index

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    bridge_state_t state_q, state_d;
    logic pending_q, pending_d;
    logic dir_q, dir_d;
    logic up_q, up_d;
    logic down_q, down_d;
    logic [3:0] lanes_q, lanes_d;
    logic [15:0] index_q, index_d;
    logic [31:0] wdata_q, wdata_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] host_rdata_q, host_rdata_d;
    logic step_after_q, step_after_d;

    logic cmd_wr;
    logic data_wr;
    logic data_rd;
    logic cmd_rd;
    logic [31:0] cmd_view;

    assign cmd_wr = host_req_i.sel && host_req_i.wr && host_req_i.addr == CMD_REG_OFFSET;
    assign data_wr = host_req_i.sel && host_req_i.wr && host_req_i.addr == DATA_REG_OFFSET;
    assign data_rd = host_req_i.sel && host_req_i.rd && host_req_i.addr == DATA_REG_OFFSET;
    assign cmd_rd = host_req_i.sel && host_req_i.rd && host_req_i.addr == CMD_REG_OFFSET;

    always_comb
    begin
        cmd_view = CMD_RESET;
        cmd_view[PENDING_BIT] = pending_q;
        cmd_view[DIR_BIT] = dir_q;
        cmd_view[STEP_UP_BIT] = up_q;
        cmd_view[STEP_DOWN_BIT] = down_q;
        cmd_view[LANE_MSB:LANE_LSB] = lanes_q;
        cmd_view[INDEX_MSB:INDEX_LSB] = index_q;
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        pending_d = pending_q;
        dir_d = dir_q;
        up_d = up_q;
        down_d = down_q;
        lanes_d = lanes_q;
        index_d = index_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        host_rdata_d = host_rdata_q;
        step_after_d = step_after_q;

        // Host accesses
        if (cmd_wr)
        begin
            dir_d = host_req_i.wdata[DIR_BIT];
            up_d = host_req_i.wdata[STEP_UP_BIT];
            down_d = host_req_i.wdata[STEP_DOWN_BIT];
            lanes_d = host_req_i.wdata[LANE_MSB:LANE_LSB];
            index_d = host_req_i.wdata[INDEX_MSB:INDEX_LSB];
            if (host_req_i.wdata[PENDING_BIT] && !pending_q)
            begin
                pending_d = 1'b1;
                step_after_d = 1'b0;
            end
        end
        else if (data_wr)
        begin
            wdata_d = host_req_i.wdata;
            if ((up_q || down_q) && !pending_q)
            begin
                pending_d = 1'b1;
                step_after_d = 1'b1;
            end
        end
        else if (data_rd && (up_q || down_q) && !pending_q)
        begin
            index_d = step_index(index_q, up_q, down_q);
            pending_d = 1'b1;
            step_after_d = 1'b0;
        end

        // Read data mux, registered for the host
        if (data_rd)
        begin
            host_rdata_d = (dir_q == DIR_READ) ? rdata_q : wdata_q;
        end
        else if (cmd_rd)
        begin
            host_rdata_d = cmd_view;
        end

        // Fabric access sequencer
        case (state_q)
            ST_IDLE:
            begin
                if (pending_q)
                begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (fabric_done_i)
                begin
                    if (dir_q == DIR_READ)
                    begin
                        rdata_d = fabric_rdata_i;
                    end
                    state_d = ST_DONE;
                end
            end
            ST_DONE:
            begin
                pending_d = 1'b0;
                if (step_after_q && dir_q == DIR_WRITE)
                begin
                    index_d = step_index(index_q, up_q, down_q);
                end
                step_after_d = 1'b0;
                state_d = ST_IDLE;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            state_q <= ST_IDLE;
            pending_q <= 1'b0;
            dir_q <= CMD_RESET[DIR_BIT];
            up_q <= CMD_RESET[STEP_UP_BIT];
            down_q <= CMD_RESET[STEP_DOWN_BIT];
            lanes_q <= CMD_RESET[LANE_MSB:LANE_LSB];
            index_q <= CMD_RESET[INDEX_MSB:INDEX_LSB];
            wdata_q <= DATA_RESET;
            rdata_q <= DATA_RESET;
            host_rdata_q <= DATA_RESET;
            step_after_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            pending_q <= pending_d;
            dir_q <= dir_d;
            up_q <= up_d;
            down_q <= down_d;
            lanes_q <= lanes_d;
            index_q <= index_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            host_rdata_q <= host_rdata_d;
            step_after_q <= step_after_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign host_rdata_o = host_rdata_q;
    assign fabric_req_o.req = (state_q == ST_WAIT);
    assign fabric_req_o.rd_nwr = dir_q;
    assign fabric_req_o.index = index_q;
    assign fabric_req_o.lanes = (dir_q == DIR_WRITE) ? lanes_q : 4'h0;
    assign fabric_req_o.wdata = wdata_q;

endmodule : fabric_bridge

//--- testbench/fabric_bridge_checker.sv
// Port assertions for the fabric bridge
`timescale 1ns/1ns
module fabric_bridge_checker
    import fabric_bridge_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Watched ports
    input fabric_bridge_pkg::host_req_t host_req_i,
    input wire logic [31:0] host_rdata_o,
    input fabric_bridge_pkg::fabric_req_t fabric_req_o,
    input wire logic fabric_done_i
);
    host_req_t h;
    fabric_req_t f;
    logic [4:0] lane_dir;
    assign h = host_req_i;
    assign f = fabric_req_o;
    // Lanes and direction watched together for the hold check
    assign lane_dir = {f.lanes, f.rd_nwr};
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_start;
        h.sel && h.wr && h.addr == CMD_REG_OFFSET && h.wdata[PENDING_BIT] && !f.req
        && $past(!f.req, 3);
    endsequence
    sequence s_launch;
        ##2 f.req && f.index == $past(h.wdata[INDEX_MSB:INDEX_LSB], 2)
        && f.rd_nwr == $past(h.wdata[DIR_BIT], 2);
    endsequence
    a_cmd_start: assert property (s_start |-> s_launch)
        else $error("command start not launched");
    a_req_hold: assert property (f.req && !fabric_done_i |=> f.req && $stable(f.index))
        else $error("request dropped early");
    a_field_hold: assert property (f.req && !fabric_done_i |=> $stable(f.wdata))
        else $error("write data moved");
    a_lane_hold: assert property (f.req && !fabric_done_i |=> $stable(lane_dir))
        else $error("lanes moved");
    a_req_drop: assert property (f.req && fabric_done_i |=> !f.req)
        else $error("request kept after done");
    a_idle_gap: assert property ($fell(f.req) |-> !f.req [*2])
        else $error("accesses too close");
    a_read_lanes: assert property (f.req && f.rd_nwr |-> f.lanes == 4'h0)
        else $error("lanes on a read");
    a_rdata_hold: assert property (!(h.sel && h.rd) |=> $stable(host_rdata_o))
        else $error("read data moved");
endmodule : fabric_bridge_checker

bind fabric_bridge fabric_bridge_checker fabric_bridge_checker_i (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .host_req_i(host_req_i),
    .host_rdata_o(host_rdata_o),
    .fabric_req_o(fabric_req_o),
    .fabric_done_i(fabric_done_i)
);

//--- testbench/fabric_model.sv
// Behavioural model of the fabric register port
`timescale 1ns/1ns
module fabric_model
    import fabric_bridge_pkg::*;
(
    // Clock and request
    input wire logic clk_sys_i,
    input fabric_bridge_pkg::fabric_req_t fabric_req_i,
    input wire logic slow_i,
    // Completion
    output logic fabric_done_o,
    output logic [31:0] fabric_rdata_o
);
    logic [31:0] mem_q [16];
    logic [2:0] wait_q;
    initial
    begin
        for (int i = 0; i < 16; i++)
            mem_q[i] = 32'hA5A5_A5A5 ^ i;
        wait_q = 3'h0;
        fabric_done_o = 1'b0;
        fabric_rdata_o = 32'h0;
    end
    // Data toggles outside completion so stale values never match
    always @(posedge clk_sys_i)
    begin
        fabric_done_o <= 1'b0;
        fabric_rdata_o <= ~fabric_rdata_o;
        if (fabric_req_i.req && !fabric_done_o)
            wait_q <= wait_q + 3'h1;
        if (fabric_req_i.req && !fabric_done_o && wait_q >= (slow_i ? 3'h4 : 3'h0))
        begin
            wait_q <= 3'h0;
            fabric_done_o <= 1'b1;
            fabric_rdata_o <= mem_q[fabric_req_i.index[3:0]];
            for (int b = 0; b < 4; b++)
                if (!fabric_req_i.rd_nwr && fabric_req_i.lanes[b])
                    mem_q[fabric_req_i.index[3:0]][8*b +: 8] <= fabric_req_i.wdata[8*b +: 8];
        end
    end
endmodule : fabric_model

//--- testbench/switch_indirect_reg_access_bench.sv
// Self-checking bench for the fabric bridge
`timescale 1ns/1ns
module switch_indirect_reg_access_bench;
    import fabric_bridge_pkg::*;
    logic clk_sys_i;
    logic rst_n_i;
    logic slow;
    logic done;
    logic [31:0] rdata;
    logic [31:0] fdata;
    host_req_t hreq;
    fabric_req_t freq;
    int err_count;
    int check_count;
    fabric_bridge fabric_bridge_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .host_req_i(hreq), .host_rdata_o(rdata), .fabric_req_o(freq),
        .fabric_done_i(done), .fabric_rdata_i(fdata));
    fabric_model fabric_model_i (.clk_sys_i(clk_sys_i), .fabric_req_i(freq),
        .slow_i(slow), .fabric_done_o(done), .fabric_rdata_o(fdata));
    initial
    begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    function automatic logic [31:0] init(int i);
        return 32'hA5A5_A5A5 ^ i;
    endfunction : init
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic wr(logic [11:0] a, logic [31:0] d);
        @(posedge clk_sys_i);
        hreq <= '{1'b1, 1'b1, 1'b0, a, d};
        @(posedge clk_sys_i);
        hreq <= '0;
    endtask : wr
    task automatic rd(logic [11:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        hreq <= '{1'b1, 1'b0, 1'b1, a, 32'h0};
        @(posedge clk_sys_i);
        hreq <= '0;
        #1 d = rdata;
    endtask : rd
    task automatic poll();
        logic [31:0] v;
        for (int n = 0; n < 40; n++)
        begin
            rd(CMD_REG_OFFSET, v);
            if (v[PENDING_BIT] === 1'b0)
                return;
        end
        err_count++;
        conclude();
    endtask : poll
    task automatic t_reset();
        logic [31:0] v;
        rd(CMD_REG_OFFSET, v);
        check("cmd", v, CMD_RESET);
        rd(DATA_REG_OFFSET, v);
        check("data", v, DATA_RESET);
        rd(12'h1B4, v);
        check("unmapped", v, DATA_RESET);
        $display("reset test done");
    endtask : t_reset
    task automatic t_lanes();
        logic [31:0] v;
        slow <= 1'b1;
        wr(DATA_REG_OFFSET, 32'h1122_3344);
        wr(CMD_REG_OFFSET, 32'h8005_0003);
        rd(CMD_REG_OFFSET, v);
        check("busy", v, 32'h8005_0003);
        rd(12'h1B4, v);
        check("unmapped hold", v, 32'h8005_0003);
        poll();
        rd(DATA_REG_OFFSET, v);
        check("echo", v, 32'h1122_3344);
        wr(CMD_REG_OFFSET, 32'hC000_0003);
        poll();
        rd(DATA_REG_OFFSET, v);
        check("lanes", v, (init(3) & 32'hFF00_FF00) | 32'h0022_0044);
        $display("lane test done");
    endtask : t_lanes
    task automatic t_step_read(logic [31:0] mode, int step);
        logic [31:0] v;
        logic [15:0] nxt;
        nxt = 16'(5 + step);
        slow <= 1'b0;
        wr(CMD_REG_OFFSET, 32'hC00F_0005 | mode);
        poll();
        rd(DATA_REG_OFFSET, v);
        check("first", v, init(5));
        poll();
        wr(CMD_REG_OFFSET, {16'h400F, nxt});
        rd(DATA_REG_OFFSET, v);
        check("last", v, init(nxt));
        rd(CMD_REG_OFFSET, v);
        check("index", v, {16'h400F, nxt});
        $display("step read test done");
    endtask : t_step_read
    task automatic t_step_write(logic [31:0] mode, int step);
        logic [31:0] v;
        slow <= 1'b1;
        wr(CMD_REG_OFFSET, 32'h000F_0009 | mode);
        wr(DATA_REG_OFFSET, 32'h0BAD_F00D ^ mode);
        poll();
        rd(CMD_REG_OFFSET, v);
        check("wr step", v, (32'h000F_0009 + step) | mode);
        wr(CMD_REG_OFFSET, 32'hC00F_0009);
        poll();
        rd(DATA_REG_OFFSET, v);
        check("wr data", v, 32'h0BAD_F00D ^ mode);
        $display("step write test done");
    endtask : t_step_write
    initial
    begin
        rst_n_i = 1'b0;
        slow = 1'b0;
        hreq = '0;
        err_count = 0;
        check_count = 0;
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        t_reset();
        t_lanes();
        t_step_read(32'h3000_0000, 1);
        t_step_read(32'h2000_0000, 1);
        t_step_read(32'h1000_0000, -1);
        t_step_write(32'h2000_0000, 1);
        t_step_write(32'h1000_0000, -1);
        conclude();
    end
endmodule : switch_indirect_reg_access_bench
